// ===== common/dwm_pkg.sv
`default_nettype none
package dwm_pkg;
   // one time base for every interval, so enable/disable ratio tracks
   localparam int unsigned DWM_CLK_NS = 25;
   localparam int unsigned DWM_QUAL_NS = 500;
   localparam int unsigned DWM_PULSE_NS = 1000;
   localparam int unsigned DWM_REP_NS = 30000;
   localparam int unsigned DWM_EN_NS = 57000;
   localparam int unsigned DWM_DIS_NS = 177000;
   localparam int unsigned DWM_HOLD_MS = 40;
   localparam int unsigned DWM_QUAL_CYC =
      (DWM_QUAL_NS + DWM_CLK_NS - 1) / DWM_CLK_NS;
   localparam int unsigned DWM_PULSE_CYC = DWM_PULSE_NS / DWM_CLK_NS;
   localparam int unsigned DWM_REP_CYC = DWM_REP_NS / DWM_CLK_NS;
   localparam int unsigned DWM_EN_CYC = DWM_EN_NS / DWM_CLK_NS;
   localparam int unsigned DWM_DIS_CYC = DWM_DIS_NS / DWM_CLK_NS;
   localparam int unsigned DWM_HOLD_CYC =
      DWM_HOLD_MS * 1000000 / DWM_CLK_NS;
   localparam int unsigned DWM_QW = 5;
   localparam int unsigned DWM_AW = 11;
   localparam int unsigned DWM_PW = 16;
   localparam int unsigned DWM_NW = 6;
   localparam int unsigned DWM_HW = 21;
   localparam logic [5:0] DWM_EN_NUM = 6'h20;
   localparam logic [5:0] DWM_DIS_NUM = 6'h3f;
   typedef enum logic [1:0] {
      DWM_IDLE = 2'b00,
      DWM_PULSE = 2'b01,
      DWM_GAP = 2'b10
   } dwm_alert_t;
endpackage
`default_nettype wire

// ===== rtl/dwm_qual.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_qual
   import dwm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic run,
   input wire logic pin_low,
   input wire logic self_drive,
   output logic strobe
);
   localparam logic [DWM_QW-1:0] QMAX = DWM_QW'(DWM_QUAL_CYC);
   logic [DWM_QW-1:0] cnt;
   logic [DWM_QW-1:0] next_cnt;
   logic next_strobe;

   always_comb begin
      next_cnt = cnt;
      next_strobe = 1'b0;
      if (!run) begin
         next_cnt = '0;
      end else if (pin_low && !self_drive) begin
         // own alert pulse pulls the pin low too; never counted
         if (cnt != QMAX) begin
            next_cnt = cnt + 1'b1;
         end
      end else if (pin_low) begin
         // cycle masked by own pulse: dropped, no strobe mid-low
         next_cnt = '0;
      end else begin
         // strobe at end of the low excursion only
         next_strobe = (cnt == QMAX);
         next_cnt = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cnt <= '0;
         strobe <= 1'b0;
      end else begin
         cnt <= next_cnt;
         strobe <= next_strobe;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/dwm_ens.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_ens
   import dwm_pkg::*;
#(
   parameter int unsigned DIS_CYC = DWM_DIS_CYC,
   parameter int unsigned EN_CYC = DWM_EN_CYC
)(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic run,
   input wire logic cyc,
   output logic ens_on
);
   localparam logic [DWM_PW-1:0] PMAX = DWM_PW'(DIS_CYC + 1);
   localparam logic [DWM_PW-1:0] EN_LIM = DWM_PW'(EN_CYC);
   localparam logic [DWM_PW-1:0] DIS_LIM = DWM_PW'(DIS_CYC);
   logic [DWM_PW-1:0] pcnt;
   logic [DWM_PW-1:0] next_pcnt;
   logic [DWM_NW-1:0] en_cnt;
   logic [DWM_NW-1:0] next_en_cnt;
   logic [DWM_NW-1:0] dis_cnt;
   logic [DWM_NW-1:0] next_dis_cnt;
   logic next_ens_on;

   always_comb begin
      next_pcnt = pcnt;
      next_en_cnt = en_cnt;
      next_dis_cnt = dis_cnt;
      next_ens_on = ens_on;
      if (!run) begin
         next_pcnt = '0;
         next_en_cnt = '0;
         next_dis_cnt = '0;
         next_ens_on = 1'b0;
      end else if (cyc) begin
         next_pcnt = '0;
         if (!ens_on) begin
            next_en_cnt = '0;
            if (pcnt > DIS_LIM) begin
               if (dis_cnt == DWM_DIS_NUM - 6'h01) begin
                  next_ens_on = 1'b1;
                  next_dis_cnt = '0;
               end else begin
                  next_dis_cnt = dis_cnt + 1'b1;
               end
            end else begin
               next_dis_cnt = '0;
            end
         end else begin
            next_dis_cnt = '0;
            // long periods keep the count, they do not clear it
            if (pcnt < EN_LIM) begin
               if (en_cnt == DWM_EN_NUM - 6'h01) begin
                  next_ens_on = 1'b0;
                  next_en_cnt = '0;
               end else begin
                  next_en_cnt = en_cnt + 1'b1;
               end
            end
         end
      end else if (pcnt != PMAX) begin
         // saturates just past the disable interval
         next_pcnt = pcnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pcnt <= '0;
         en_cnt <= '0;
         dis_cnt <= '0;
         ens_on <= 1'b0;
      end else begin
         pcnt <= next_pcnt;
         en_cnt <= next_en_cnt;
         dis_cnt <= next_dis_cnt;
         ens_on <= next_ens_on;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/dwm_top.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_top
   import dwm_pkg::*;
#(
   parameter int unsigned DIS_CYC = DWM_DIS_CYC,
   parameter int unsigned EN_CYC = DWM_EN_CYC,
   parameter int unsigned HOLD_CYC = DWM_HOLD_CYC
)(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic undervoltage_lockout_ok,
   input wire logic alert_pin_in,
   input wire logic droop_cmp,
   output logic sample_strobe,
   output logic alert_pin_out,
   output logic alert_pin_oe,
   output logic ens_pin_out,
   output logic ens_pin_oe,
   output logic ref_stale
);
   localparam logic [DWM_AW-1:0] PULSE_END = DWM_AW'(DWM_PULSE_CYC - 1);
   localparam logic [DWM_AW-1:0] REP_END = DWM_AW'(DWM_REP_CYC - 1);
   localparam logic [DWM_HW-1:0] HOLD_MAX = DWM_HW'(HOLD_CYC);
   localparam logic [DWM_AW-1:0] PULSE_LEN = DWM_AW'(DWM_PULSE_CYC);
   localparam logic [DWM_AW-1:0] REP_LEN = DWM_AW'(DWM_REP_CYC);
   localparam logic [DWM_AW-1:0] REP_SAT = '1;

   logic run;
   logic next_run;
   dwm_alert_t state;
   dwm_alert_t next_state;
   logic [DWM_AW-1:0] acnt;
   logic [DWM_AW-1:0] next_acnt;
   logic next_alert_oe;
   logic [DWM_HW-1:0] hcnt;
   logic [DWM_HW-1:0] next_hcnt;
   logic next_ref_stale;
   logic [DWM_AW-1:0] oe_len;
   logic [DWM_AW-1:0] next_oe_len;
   logic [DWM_AW-1:0] rep_cnt;
   logic [DWM_AW-1:0] next_rep_cnt;
   logic held;
   logic next_held;
   logic broke;
   logic next_broke;

   // pin input high means below the cycle detect threshold
   dwm_qual u_qual (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .run(run),
      .pin_low(alert_pin_in),
      .self_drive(alert_pin_oe),
      .strobe(sample_strobe)
   );

   // the strobe refreshes the reference whenever it comes,
   // droop or not, which lets a new 3 % droop start over

   // fed only by qualified cycles, so alerts cannot disturb it
   dwm_ens #(
      .DIS_CYC(DIS_CYC),
      .EN_CYC(EN_CYC)
   ) u_ens (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .run(run),
      .cyc(sample_strobe),
      .ens_on(ens_pin_oe)
   );

   always_comb begin
      next_run = undervoltage_lockout_ok;
   end

   always_comb begin
      next_state = state;
      next_acnt = acnt;
      if (!run) begin
         next_state = DWM_IDLE;
         next_acnt = '0;
      end else begin
         case (state)
            DWM_IDLE: begin
               if (droop_cmp) begin
                  next_state = DWM_PULSE;
                  next_acnt = '0;
               end
            end
            DWM_PULSE: begin
               // pulse is cut short only by lockout (run low), dissipation stays bounded
               next_acnt = acnt + 1'b1;
               if (acnt == PULSE_END) begin
                  next_state = DWM_GAP;
               end
            end
            DWM_GAP: begin
               next_acnt = acnt + 1'b1;
               if (sample_strobe) begin
                  next_state = DWM_IDLE;
                  next_acnt = '0;
               end else if (acnt == REP_END) begin
                  next_acnt = '0;
                  if (droop_cmp) begin
                     next_state = DWM_PULSE;
                  end else begin
                     next_state = DWM_IDLE;
                  end
               end
            end
            default: begin
               next_state = DWM_IDLE;
               next_acnt = '0;
            end
         endcase
      end
      next_alert_oe = (next_state == DWM_PULSE);
   end

   always_comb begin
      next_hcnt = hcnt;
      if (!run || sample_strobe) begin
         next_hcnt = '0;
      end else if (hcnt != HOLD_MAX) begin
         next_hcnt = hcnt + 1'b1;
      end
      // no reference during lockout (run low), so stale as well
      next_ref_stale = (next_hcnt == HOLD_MAX) || !run;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         run <= 1'b0;
         state <= DWM_IDLE;
         acnt <= '0;
         alert_pin_oe <= 1'b0;
         alert_pin_out <= 1'b0;
         ens_pin_out <= 1'b0;
         hcnt <= '0;
         ref_stale <= 1'b1;
      end else begin
         run <= next_run;
         state <= next_state;
         acnt <= next_acnt;
         alert_pin_oe <= next_alert_oe;
         alert_pin_out <= 1'b0;
         ens_pin_out <= 1'b0;
         hcnt <= next_hcnt;
         ref_stale <= next_ref_stale;
      end
   end

   // checker helpers only: pulse length, cycles since a pulse began,
   // and whether the repeat conditions held all the way
   always_comb begin
      next_oe_len = '0;
      next_rep_cnt = rep_cnt;
      next_held = held && run && droop_cmp && !sample_strobe;
      next_broke = broke || sample_strobe || !run;
      if (alert_pin_oe) begin
         next_oe_len = oe_len + 1'b1;
      end
      if (alert_pin_oe && oe_len == '0) begin
         next_rep_cnt = DWM_AW'(1);
         next_held = 1'b1;
         next_broke = 1'b0;
      end else if (rep_cnt != REP_SAT) begin
         next_rep_cnt = rep_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         oe_len <= '0;
         rep_cnt <= REP_SAT;
         held <= 1'b0;
         broke <= 1'b1;
      end else begin
         oe_len <= next_oe_len;
         rep_cnt <= next_rep_cnt;
         held <= next_held;
         broke <= next_broke;
      end
   end

   // counters all tick on clk_sys, so the two intervals keep their ratio

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   a_qual_min_low: assert property (
      sample_strobe |-> $past(alert_pin_in, 2) && $past(alert_pin_in, 21)
   ) else $error("strobe without a long enough low");

   a_strobe_at_end: assert property (
      sample_strobe |-> !$past(alert_pin_in)
   ) else $error("strobe while pin still low");

   a_short_ignored: assert property (
      $rose(alert_pin_in) ##1 alert_pin_in[*8] ##1 !alert_pin_in
      |=> !sample_strobe
   ) else $error("short low produced a strobe");

   a_alert_start: assert property (
      run && state == DWM_IDLE && droop_cmp |=> alert_pin_oe
   ) else $error("droop did not start an alert pulse");

   a_pulse_width: assert property (
      alert_pin_oe |-> oe_len < PULSE_LEN
   ) else $error("alert pulse too long");

   a_pulse_full: assert property (
      $fell(alert_pin_oe) && run && $past(run) |-> oe_len == PULSE_LEN
   ) else $error("alert pulse cut short");

   a_pulse_repeat: assert property (
      rep_cnt == REP_LEN && held |-> alert_pin_oe
   ) else $error("alert pulse not repeated");

   a_repeat_floor: assert property (
      $rose(alert_pin_oe) |-> rep_cnt >= REP_LEN || broke
   ) else $error("alert pulse repeated too soon");

   a_alert_droop: assert property (
      $rose(alert_pin_oe) |-> $past(droop_cmp)
   ) else $error("alert pulse without a droop");

   a_stop_on_cycle: assert property (
      state == DWM_GAP && sample_strobe && run |=> !alert_pin_oe[*8]
   ) else $error("alert continued after qualified cycle");

   a_lockout_quiet: assert property (
      !run |=> !alert_pin_oe && !sample_strobe && !ens_pin_oe
   ) else $error("activity during lockout");

   a_ens_cycle_only: assert property (
      $changed(ens_pin_oe) |-> $past(sample_strobe) || !$past(run)
   ) else $error("enable switch changed without a cycle");

   a_alert_no_ens: assert property (
      $rose(alert_pin_oe) && !$past(sample_strobe)
      |-> ens_pin_oe == $past(ens_pin_oe)
   ) else $error("alert disturbed enable switch");

   a_stale_clear: assert property (
      run && sample_strobe |=> !ref_stale
   ) else $error("reference still stale after a cycle");

   a_strobe_single: assert property (
      sample_strobe |=> !sample_strobe
   ) else $error("strobe longer than one cycle");

   a_self_ignored: assert property (
      alert_pin_oe && alert_pin_in |=> !sample_strobe
   ) else $error("own alert pulse taken as a cycle");

   a_lockout_stale: assert property (
      !run |=> ref_stale
   ) else $error("reference not stale during lockout");

   a_pins_open_drain: assert property (
      !alert_pin_out && !ens_pin_out
   ) else $error("open-drain value driven high");

   a_ens_idle_start: assert property (
      run && !$past(run) |-> !ens_pin_oe
   ) else $error("enable switch on at start of operation");

   c_alert: cover property ($rose(alert_pin_oe));
   c_cycle_in_gap: cover property (state == DWM_GAP && sample_strobe);
   c_ens_on: cover property ($rose(ens_pin_oe));
   c_ens_off: cover property ($fell(ens_pin_oe));
   c_repeat: cover property (rep_cnt == REP_LEN && alert_pin_oe);
endmodule
`default_nettype wire

// ===== dv/dwm_primary_model.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_primary_model (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [7:0] len,
   input wire logic answer,
   input wire logic wake_oe,
   output logic pin_low
);
   logic [7:0] left = 8'h00;
   logic [7:0] delay = 8'h00;
   logic oe_d = 1'b0;
   // a wake pulse is answered with a full power cycle 100 cycles later
   always @(posedge clk_sys) begin
      oe_d <= wake_oe;
      if (answer && oe_d && !wake_oe)
         delay <= 8'h64;
      else if (delay != 8'h00)
         delay <= delay - 8'h01;
      if (go) begin
         pin_low <= 1'b1;
         left <= len;
      end else if (delay == 8'h01) begin
         pin_low <= 1'b1;
         left <= 8'h18;
      end else if (left > 8'h01) begin
         left <= left - 8'h01;
      end else begin
         pin_low <= 1'b0;
         left <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ===== dv/dwm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_top_tb
   import dwm_pkg::*;
;
   // scaled intervals keep the run short; ratio near the nominal one
   localparam int DIS = 620;
   localparam int EN = 200;
   localparam int HOLD = 1000;
   localparam int LIMIT = 80000;
   logic clk_sys, nrst, undervoltage_lockout_ok, droop_cmp, go, answer;
   logic oe_d = 1'b0;
   logic [7:0] len;
   logic [15:0] rnd;
   wire logic pin_low, sample_strobe, alert_pin_oe, ens_pin_oe, ref_stale;
   wire logic alert_pin_in, alert_pin_out, ens_pin_out;
   int cyc, mismatches, checks_done, rise_at, e;
   int sq[$];
   int aq[$];
   assign alert_pin_in = pin_low | alert_pin_oe;
   dwm_top #(.DIS_CYC(DIS), .EN_CYC(EN), .HOLD_CYC(HOLD)) u_dwm_top (
      .clk_sys(clk_sys), .nrst(nrst), .undervoltage_lockout_ok(undervoltage_lockout_ok),
      .alert_pin_in(alert_pin_in), .droop_cmp(droop_cmp),
      .sample_strobe(sample_strobe), .alert_pin_out(alert_pin_out),
      .alert_pin_oe(alert_pin_oe), .ens_pin_out(ens_pin_out),
      .ens_pin_oe(ens_pin_oe), .ref_stale(ref_stale));
   dwm_primary_model u_dwm_primary_model (
      .clk_sys(clk_sys), .go(go), .len(len), .answer(answer),
      .wake_oe(alert_pin_oe), .pin_low(pin_low));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task summarize;
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // notes a strobe only for lows long enough to qualify while running
   task wait_end(input logic [7:0] n);
      @(negedge clk_sys);
      while (pin_low !== 1'b1) @(negedge clk_sys);
      while (pin_low === 1'b1) @(negedge clk_sys);
      if (n >= 8'd20 && undervoltage_lockout_ok) sq.push_back(cyc + 1);
   endtask
   task pcycle(input logic [7:0] n);
      @(posedge clk_sys);
      go <= 1'b1;
      len <= n;
      @(posedge clk_sys);
      go <= 1'b0;
      wait_end(n);
   endtask
   task droop_on(input int reps);
      @(posedge clk_sys);
      droop_cmp <= 1'b1;
      @(negedge clk_sys);
      for (int i = 0; i < reps; i++) aq.push_back(cyc + 1 + i * DWM_REP_CYC);
   endtask
   task droop_off;
      @(posedge clk_sys);
      droop_cmp <= 1'b0;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         mismatches++;
         summarize();
      end
   end
   // one-cycle latency slack: the rules fix no exact figure here
   always @(negedge clk_sys) begin
      if (sample_strobe === 1'b1) begin
         if (sq.size() == 0) begin
            chk("strobe count", 1, 0);
         end else begin
            e = sq.pop_front();
            chk("strobe time", cyc >= e && cyc <= e + 1, 1);
         end
      end
      if (alert_pin_oe === 1'b1 && oe_d !== 1'b1) begin
         rise_at = cyc;
         if (aq.size() == 0) begin
            chk("alert count", 1, 0);
         end else begin
            e = aq.pop_front();
            chk("alert time", cyc >= e && cyc <= e + 1, 1);
         end
      end
      if (alert_pin_oe === 1'b0 && oe_d === 1'b1 && undervoltage_lockout_ok)
         chk("pulse width", cyc - rise_at, DWM_PULSE_CYC);
      oe_d = alert_pin_oe;
   end
   initial begin
      nrst = 1'b0;
      undervoltage_lockout_ok = 1'b1;
      droop_cmp = 1'b0;
      go = 1'b0;
      len = 8'h00;
      answer = 1'b0;
      rnd = 16'h0007;
      cyc = 0;
      mismatches = 0;
      checks_done = 0;
      idle(16);
      @(negedge clk_sys);
      chk("ens reset", ens_pin_oe, 0);
      chk("alert reset", alert_pin_oe, 0);
      chk("stale reset", ref_stale, 1);
      @(posedge clk_sys);
      nrst <= 1'b1;
      idle(4);
      pcycle(8'd9);
      pcycle(8'd19);
      idle(50);
      pcycle(8'd20);
      idle(10);
      chk("stale fresh", ref_stale, 0);
      idle(HOLD);
      chk("stale old", ref_stale, 1);
      droop_on(2);
      idle(1250);
      pcycle(8'd24);
      droop_off();
      idle(1300);
      droop_on(1);
      idle(20);
      undervoltage_lockout_ok <= 1'b0;
      idle(3);
      chk("lockout alert", alert_pin_oe, 0);
      pcycle(8'd25);
      droop_off();
      idle(5);
      chk("lockout stale", ref_stale, 1);
      undervoltage_lockout_ok <= 1'b1;
      idle(4);
      for (int i = 0; i < 69; i++) begin
         rnd = lfsr(rnd);
         idle(i == 5 ? 500 : 600 + rnd[5:0]);
         pcycle(8'd24);
         if (i == 67) chk("ens hold", ens_pin_oe, 0);
      end
      idle(3);
      chk("ens on", ens_pin_oe, 1);
      answer <= 1'b1;
      droop_on(1);
      wait_end(8'd24);
      droop_off();
      answer <= 1'b0;
      chk("ens alert", ens_pin_oe, 1);
      for (int i = 0; i < 34; i++) begin
         rnd = lfsr(rnd);
         idle(i < 3 ? 400 : 100 + rnd[5:0]);
         pcycle(8'd24);
         idle(3);
         if (i == 32) chk("ens keep", ens_pin_oe, 1);
      end
      chk("ens off", ens_pin_oe, 0);
      chk("notes left", sq.size() + aq.size(), 0);
      chk("alert out", alert_pin_out, 0);
      chk("ens out", ens_pin_out, 0);
      summarize();
   end
endmodule
`default_nettype wire
